// ---- shared/link_state_pkg.sv ----
// Purpose: Constants and types for the USB device link-state block
// Assumes: 100 MHz system clock
// Notes:   Times are given in their own unit; cycle counts derive from them
package link_state_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned FRAME_US        = 1000;
  localparam int unsigned SUSPEND_MS      = 3;
  localparam int unsigned WAKE_MS         = 10;
  localparam int unsigned FRAME_CYCLES    = FRAME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SUSPEND_CYCLES  = SUSPEND_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_CYCLES     = WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned NUM_EP          = 16;
  localparam int unsigned EP_W            = 4;
  localparam int unsigned ADDR_W          = 7;
  localparam int unsigned ISO_MAX_BYTES   = 1023;
  localparam int unsigned LEN_W           = 11;
  localparam int unsigned TIMER_W         = 32;
  localparam logic [6:0]  DEFAULT_ADDR    = 7'h00;
  localparam logic [3:0]  CONTROL_EP      = 4'h0;

  typedef enum logic [1:0] {
    XFER_CONTROL = 2'h0,
    XFER_ISO     = 2'h1,
    XFER_BULK    = 2'h2,
    XFER_INTR    = 2'h3
  } xfer_type_t;

  typedef enum logic [3:0] {
    ST_DEFAULT    = 4'b0001,
    ST_ADDRESSED  = 4'b0010,
    ST_CONFIGURED = 4'b0100,
    ST_SUSPENDED  = 4'b1000
  } dev_state_t;

endpackage

// ---- shared/tick_if.sv ----
// Purpose: Carrier between link-state top and its interval timer
// Assumes: One clock domain
// Notes:   restart clears the count, expired is a level
`timescale 1ns/1ps
interface tick_if;
  logic restart;
  logic run;
  logic expired;
  modport owner (output restart, output run, input expired);
  modport timer (input restart, input run, output expired);
endinterface // tick_if

// ---- rtl/interval_timer.sv ----
// Purpose: Counts cycles while running and flags when a limit is reached
// Assumes: Limit at least one cycle
// Notes:   Restart wins over counting
`timescale 1ns/1ps
module interval_timer #(
  parameter int unsigned LIMIT = 1000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Control
  tick_if.timer     tick
);
  import link_state_pkg::*;

  logic [TIMER_W-1:0] count_reg;
  logic [TIMER_W-1:0] count_next;
  logic               exp_reg;
  logic               exp_next;

  always_comb begin
    count_next = count_reg;
    exp_next   = exp_reg;
    if (tick.restart) begin
      count_next = '0;
      exp_next   = 1'b0;
    end else if (tick.run && !exp_reg) begin
      count_next = count_reg + 1'b1;
      exp_next   = (count_reg == TIMER_W'(LIMIT - 1));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      exp_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      exp_reg   <= exp_next;
    end
  end

  assign tick.expired = exp_reg;

endmodule // interval_timer

// ---- rtl/usb_device_link_state.sv ----
// Purpose: Link-level state of a full/low speed USB device function
// Assumes: Decoded bus events arrive as one-cycle pulses on clk
// Notes:   Bus activity and reset inputs come from the pins side
//
// Overview of operation
// - Track 1 ms frames, counted from SOF
// - Sixteen bidirectional endpoint numbers accepted
// - Endpoint zero is always a control endpoint
// - Isochronous payloads limited to 1023 bytes
// - Low speed allows only interrupt and control
// - Suspend after 3 ms without SOF or bus activity
// - Remote wake-up drives resume for 10 ms
// - Bus reset: unconfigured, default address zero
// - Pull-up on D+ full, D- low speed
// - Engine runs from 100 MHz system clock
`timescale 1ns/1ps
module usb_device_link_state #(
  parameter int unsigned SUSPEND_LIMIT = link_state_pkg::SUSPEND_CYCLES,
  parameter int unsigned WAKE_LIMIT    = link_state_pkg::WAKE_CYCLES,
  parameter int unsigned FRAME_LIMIT   = link_state_pkg::FRAME_CYCLES
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // Bus-side events (asynchronous to clk)
  input  wire logic                          bus_reset,
  input  wire logic                          bus_active,
  // Decoded token events (clk domain)
  input  wire logic                          sof_seen,
  input  wire logic                          token_valid,
  input  wire logic [link_state_pkg::ADDR_W-1:0] token_addr,
  input  wire logic [link_state_pkg::EP_W-1:0]   token_ep,
  input  wire logic                          token_in,
  input  wire link_state_pkg::xfer_type_t    token_type,
  input  wire logic [link_state_pkg::LEN_W-1:0]  token_len,
  // Firmware control
  input  wire logic                          attach,
  input  wire logic                          low_speed,
  input  wire logic                          set_addr,
  input  wire logic [link_state_pkg::ADDR_W-1:0] new_addr,
  input  wire logic                          set_config,
  input  wire logic                          config_value,
  input  wire logic                          wake_request,
  // Status and pins
  output logic                               pullup_dp,
  output logic                               pullup_dm,
  output logic                               suspended,
  output logic                               resume_drive,
  output logic                               frame_tick,
  output logic [link_state_pkg::ADDR_W-1:0]  dev_addr,
  output logic                               configured,
  output logic                               token_accept,
  output logic                               token_ctrl,
  output logic                               token_reject,
  output logic                               token_dir_in
);
  import link_state_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic [1:0] act_sync_reg;
  logic       bus_rst_s;
  logic       bus_act_s;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
      act_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], bus_reset};
      act_sync_reg <= {act_sync_reg[0], bus_active};
    end
  end

  assign bus_rst_s = rst_sync_reg[1];
  assign bus_act_s = act_sync_reg[1];

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  tick_if idle_t ();
  tick_if wake_t ();
  tick_if frame_t ();

  interval_timer #(.LIMIT(SUSPEND_LIMIT)) u_idle (
    .clk  (clk),
    .nrst (nrst),
    .tick (idle_t)
  );

  interval_timer #(.LIMIT(WAKE_LIMIT)) u_wake (
    .clk  (clk),
    .nrst (nrst),
    .tick (wake_t)
  );

  // Restart on expiry costs a cycle, so the limit is one short
  interval_timer #(.LIMIT(FRAME_LIMIT - 1)) u_frame (
    .clk  (clk),
    .nrst (nrst),
    .tick (frame_t)
  );

  dev_state_t state_reg;
  dev_state_t state_next;
  dev_state_t resume_to_reg;
  dev_state_t resume_to_next;
  logic       wake_pend_reg;
  logic       wake_pend_next;

  assign idle_t.restart  = sof_seen || bus_act_s || bus_rst_s;
  assign idle_t.run      = attach && (state_reg != ST_SUSPENDED);
  assign wake_t.restart  = !wake_pend_reg;
  assign wake_t.run      = wake_pend_reg;
  assign frame_t.restart = sof_seen || frame_t.expired;
  assign frame_t.run     = attach;

  // ----------------------------------------------------------------
  // Device state
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic              resume_reg;
  logic              resume_next;
  logic              susp_reg;
  logic              susp_next;
  logic              cfg_reg;
  logic              cfg_next;

  always_comb begin
    state_next     = state_reg;
    resume_to_next = resume_to_reg;
    addr_next      = addr_reg;
    wake_pend_next = wake_pend_reg;
    resume_next    = 1'b0;
    if (!attach || bus_rst_s) begin
      state_next     = ST_DEFAULT;
      addr_next      = DEFAULT_ADDR;
      wake_pend_next = 1'b0;
    end else begin
      case (state_reg)
        ST_DEFAULT: begin
          if (set_addr && new_addr != DEFAULT_ADDR) begin
            addr_next  = new_addr;
            state_next = ST_ADDRESSED;
          end else if (idle_t.expired) begin
            resume_to_next = ST_DEFAULT;
            state_next     = ST_SUSPENDED;
          end
        end
        ST_ADDRESSED: begin
          if (set_config && config_value) begin
            state_next = ST_CONFIGURED;
          end else if (set_addr) begin
            addr_next = new_addr;
            if (new_addr == DEFAULT_ADDR) begin
              state_next = ST_DEFAULT;
            end
          end else if (idle_t.expired) begin
            resume_to_next = ST_ADDRESSED;
            state_next     = ST_SUSPENDED;
          end
        end
        ST_CONFIGURED: begin
          if (set_config && !config_value) begin
            state_next = ST_ADDRESSED;
          end else if (idle_t.expired) begin
            resume_to_next = ST_CONFIGURED;
            state_next     = ST_SUSPENDED;
          end
        end
        ST_SUSPENDED: begin
          if (sof_seen || bus_act_s) begin
            state_next     = resume_to_reg;
            wake_pend_next = 1'b0;
          end else if (wake_request && !wake_pend_reg) begin
            wake_pend_next = 1'b1;
          end else if (wake_pend_reg && wake_t.expired) begin
            wake_pend_next = 1'b0;
          end else if (wake_pend_reg) begin
            resume_next = 1'b1;
          end
        end
        default: begin
          state_next = ST_DEFAULT;
        end
      endcase
    end
    susp_next = (state_next == ST_SUSPENDED);
    cfg_next  = (state_next == ST_CONFIGURED);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_DEFAULT;
      resume_to_reg <= ST_DEFAULT;
      addr_reg      <= DEFAULT_ADDR;
      susp_reg      <= 1'b0;
      cfg_reg       <= 1'b0;
      wake_pend_reg <= 1'b0;
      resume_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      resume_to_reg <= resume_to_next;
      addr_reg      <= addr_next;
      wake_pend_reg <= wake_pend_next;
      resume_reg    <= resume_next;
      susp_reg      <= susp_next;
      cfg_reg       <= cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // Token screening
  // ----------------------------------------------------------------
  logic tok_ok;
  logic acc_reg;
  logic ctrl_reg;
  logic rej_reg;
  logic dir_reg;
  logic frame_reg;
  logic pdp_reg;
  logic pdm_reg;

  always_comb begin
    tok_ok = token_valid && attach && (state_reg != ST_SUSPENDED)
             && (token_addr == addr_reg);
    if (token_ep == CONTROL_EP && token_type != XFER_CONTROL) begin
      tok_ok = 1'b0;
    end
    if (low_speed && (token_type == XFER_ISO || token_type == XFER_BULK)) begin
      tok_ok = 1'b0;
    end
    if (token_type == XFER_ISO && token_len > LEN_W'(ISO_MAX_BYTES)) begin
      tok_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg   <= 1'b0;
      ctrl_reg  <= 1'b0;
      rej_reg   <= 1'b0;
      dir_reg   <= 1'b0;
      frame_reg <= 1'b0;
      pdp_reg   <= 1'b0;
      pdm_reg   <= 1'b0;
    end else begin
      acc_reg   <= tok_ok;
      ctrl_reg  <= tok_ok && (token_ep == CONTROL_EP);
      rej_reg   <= token_valid && !tok_ok && (token_addr == addr_reg);
      dir_reg   <= token_in;
      frame_reg <= sof_seen || frame_t.expired;
      pdp_reg   <= attach && !low_speed;
      pdm_reg   <= attach && low_speed;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pullup_dp    = pdp_reg;
  assign pullup_dm    = pdm_reg;
  assign suspended    = susp_reg;
  assign resume_drive = resume_reg;
  assign frame_tick   = frame_reg;
  assign dev_addr     = addr_reg;
  assign configured   = cfg_reg;
  assign token_accept = acc_reg;
  assign token_ctrl   = ctrl_reg;
  assign token_reject = rej_reg;
  assign token_dir_in = dir_reg;

endmodule // usb_device_link_state

// ---- verif/link_state_sva.sv ----
// Purpose: Port-level checks of the USB device link-state block
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to the top module by name
`timescale 1ns/1ps
module link_state_sva
  import link_state_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // Inputs watched
  input wire logic               bus_reset,
  input wire logic               bus_active,
  input wire logic               sof_seen,
  input wire logic               token_valid,
  input wire logic [3:0]         token_ep,
  input wire link_state_pkg::xfer_type_t token_type,
  input wire logic [10:0]        token_len,
  input wire logic               attach,
  input wire logic               low_speed,
  input wire logic               wake_request,
  // Outputs watched
  input wire logic               pullup_dp,
  input wire logic               pullup_dm,
  input wire logic               suspended,
  input wire logic               resume_drive,
  input wire logic               frame_tick,
  input wire logic [6:0]         dev_addr,
  input wire logic               configured,
  input wire logic               token_accept
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_pullup_full: assert property (attach && !low_speed |=>
    pullup_dp && !pullup_dm) else $error("full speed pull-up wrong");
  a_pullup_low: assert property (attach && low_speed |=>
    pullup_dm && !pullup_dp) else $error("low speed pull-up wrong");
  a_detach_default: assert property (!attach |=>
    !pullup_dp && !pullup_dm && dev_addr == 7'h00)
    else $error("detached state wrong");
  a_sof_tick: assert property (sof_seen |=> frame_tick)
    else $error("no frame tick after start of frame");
  a_ep0_control: assert property (token_valid && token_ep == 4'h0 &&
    token_type != XFER_CONTROL |=> !token_accept)
    else $error("endpoint zero took non-control token");
  a_iso_length: assert property (token_valid &&
    token_type == XFER_ISO && token_len > 11'h3ff |=> !token_accept)
    else $error("oversize isochronous token accepted");
  a_low_types: assert property (token_valid && low_speed &&
    (token_type == XFER_ISO || token_type == XFER_BULK) |=> !token_accept)
    else $error("low speed took iso or bulk token");
  a_reset_addr: assert property (bus_reset[*4] |=>
    dev_addr == 7'h00 && !configured) else $error("bus reset ignored");
  a_wake_time: assert property (wake_request && suspended |->
    ##[1:3] resume_drive) else $error("wake signalling late");
  a_resume_exit: assert property (suspended && bus_active |->
    ##[1:4] !suspended) else $error("activity did not end suspend");
endmodule // link_state_sva

bind usb_device_link_state link_state_sva u_sva (.*);

// ---- verif/host_link_model.sv ----
// Purpose: Host side model issuing start-of-frame events
// Assumes: Frame period given in clk cycles
// Notes:   Frames stop at once when sof_on drops
`timescale 1ns/1ps
module host_link_model #(
  parameter int unsigned PERIOD = 20
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sof_on,
  output logic      sof_seen
);
  int unsigned cnt;
  // One start-of-frame pulse per frame period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt      <= 0;
      sof_seen <= 1'b0;
    end else begin
      sof_seen <= sof_on && cnt == PERIOD - 1;
      cnt      <= (!sof_on || cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
  end
endmodule // host_link_model

// ---- verif/tb_usb_device_link_state.sv ----
// Purpose: Self-checking bench of the USB device link-state block
// Assumes: Short timer limits for simulation
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_usb_device_link_state;
  import link_state_pkg::*;
  localparam int unsigned SL = 50;
  localparam int unsigned FL = 20;
  logic clk, nrst, bus_reset, bus_active, sof_seen, sof_on, token_valid;
  logic token_in, attach, low_speed, set_addr, set_config, config_value;
  logic wake_request, pullup_dp, pullup_dm, suspended, resume_drive;
  logic frame_tick, configured, token_accept, token_ctrl, token_reject;
  logic token_dir_in;
  logic [6:0] token_addr, new_addr, dev_addr;
  logic [3:0] token_ep;
  logic [10:0] token_len;
  xfer_type_t token_type;
  int miscompares, tests_run;

  usb_device_link_state #(.SUSPEND_LIMIT(SL), .WAKE_LIMIT(80),
    .FRAME_LIMIT(FL)) u_dut (.*);
  host_link_model #(.PERIOD(FL)) u_host (.clk, .nrst, .sof_on, .sof_seen);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    tests_run++;
    if (g !== e) begin
      $display("unexpected at %0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask

  task automatic tok(input logic [6:0] a, input logic [3:0] e,
      input xfer_type_t t, input logic [10:0] l, input logic d,
      input logic acc, input logic rej);
    token_addr = a;
    token_ep = e;
    token_type = t;
    token_len = l;
    token_in = d;
    token_valid = 1'b1;
    step(1);
    token_valid = 1'b0;
    chk(token_accept, acc);
    chk(token_reject, rej);
    chk(token_ctrl, acc && e == 4'h0);
    if (acc) chk(token_dir_in, d);
    step(1);
  endtask

  task automatic t_frame;
    int unsigned n;
    step(1);
    sof_on = 1'b0;
    bus_active = 1'b1;
    n = 0;
    while (frame_tick !== 1'b1 && n < 3 * FL) begin
      step(1);
      n++;
    end
    n = 0;
    do begin
      step(1);
      n++;
    end while (frame_tick !== 1'b1 && n < 3 * FL);
    chk(11'(n), 11'(FL));
    sof_on = 1'b1;
    bus_active = 1'b0;
    $display("frame test done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic t_speed;
    attach = 1'b1; sof_on = 1'b1; low_speed = 1'b1;
    step(2);
    chk(pullup_dm, 1); chk(pullup_dp, 0);
    low_speed = 1'b0;
    step(2);
    chk(pullup_dp, 1); chk(pullup_dm, 0);
    $display("speed test done");
  endtask

  task automatic t_tokens;
    tok(0, 0, XFER_CONTROL, 8, 0, 1, 0);
    tok(0, 0, XFER_BULK, 8, 1, 0, 1);
    tok(0, 15, XFER_BULK, 64, 1, 1, 0);
    tok(0, 15, XFER_BULK, 64, 0, 1, 0);
    tok(0, 1, XFER_ISO, 1023, 0, 1, 0);
    tok(0, 1, XFER_ISO, 1024, 0, 0, 1);
    tok(5, 1, XFER_BULK, 8, 0, 0, 0);
    low_speed = 1'b1;
    tok(0, 1, XFER_BULK, 8, 0, 0, 1);
    tok(0, 1, XFER_ISO, 8, 0, 0, 1);
    tok(0, 2, XFER_INTR, 8, 1, 1, 0);
    low_speed = 1'b0;
    $display("token test done");
  endtask

  task automatic t_enum;
    set_addr = 1'b1; new_addr = 7'h05;
    step(1);
    set_addr = 1'b0;
    chk(dev_addr, 5); chk(configured, 0);
    set_config = 1'b1; config_value = 1'b1;
    step(1);
    set_config = 1'b0;
    chk(configured, 1);
    tok(5, 0, XFER_CONTROL, 8, 0, 1, 0);
    tok(0, 1, XFER_BULK, 8, 0, 0, 0);
    chk(suspended, 0);
    $display("enumeration test done");
  endtask

  task automatic t_suspend;
    sof_on = 1'b0;
    step(25);
    chk(suspended, 0);
    step(30);
    chk(suspended, 1);
    wake_request = 1'b1;
    step(1);
    wake_request = 1'b0;
    step(2);
    chk(resume_drive, 1);
    bus_active = 1'b1;
    step(5);
    chk(suspended, 0); chk(resume_drive, 0); chk(configured, 1);
    sof_on = 1'b1; bus_active = 1'b0;
    $display("suspend test done");
  endtask

  task automatic t_reset;
    bus_reset = 1'b1;
    step(4);
    bus_reset = 1'b0;
    step(1);
    chk(dev_addr, 0); chk(configured, 0);
    attach = 1'b0;
    step(2);
    chk(pullup_dp, 0); chk(pullup_dm, 0);
    $display("reset test done");
  endtask

  initial begin
    nrst = 1'b0; bus_reset = 1'b0; bus_active = 1'b0; sof_on = 1'b0;
    token_valid = 1'b0; token_in = 1'b0; attach = 1'b0; low_speed = 1'b0;
    set_addr = 1'b0; set_config = 1'b0; config_value = 1'b0;
    wake_request = 1'b0; token_addr = 7'h00; new_addr = 7'h00;
    token_ep = 4'h0; token_len = 11'h000; token_type = XFER_CONTROL;
    miscompares = 0; tests_run = 0;
    step(8);
    nrst = 1'b1;
    step(1);
    t_speed();
    t_tokens();
    t_enum();
    t_suspend();
    t_frame();
    t_reset();
    wrap_up();
  end

  initial begin
    #100us;
    miscompares++;
    wrap_up();
  end
endmodule // tb_usb_device_link_state
